//--- hw/crs_pkg.sv
// package: system register numbers, field layouts, reset values, command carriers
package crs_pkg;
	// ===================================================
	// widths and fixed fields
	localparam int XLEN        = 32;
	localparam int PC_BITS     = 26;
	localparam int STAT_BITS   = 8;
	localparam int REG_AW      = 5;
	localparam logic [4:0] ZERO_REG_IDX    = 5'h00;
	localparam logic [4:0] ELEM_BASE_IDX   = 5'h1e;
	// ===================================================
	// system register numbers
	localparam logic [4:0] SR_EXC_RET_PC   = 5'h00;
	localparam logic [4:0] SR_EXC_STAT     = 5'h01;
	localparam logic [4:0] SR_NMI_RET_PC   = 5'h02;
	localparam logic [4:0] SR_NMI_STAT     = 5'h03;
	localparam logic [4:0] SR_CAUSE        = 5'h04;
	localparam logic [4:0] SR_PSW          = 5'h05;
	localparam logic [4:0] SR_TC_RET_PC    = 5'h10;
	localparam logic [4:0] SR_TC_STAT      = 5'h11;
	localparam logic [4:0] SR_DBG_RET_PC   = 5'h12;
	localparam logic [4:0] SR_DBG_STAT     = 5'h13;
	localparam logic [4:0] SR_TC_BASE      = 5'h14;
	// ===================================================
	// reset values
	localparam logic [31:0] PSW_RESET      = 32'h0000_0020;
	localparam logic [31:0] PC_RESET       = 32'h0000_0000;
	localparam logic [31:0] SR_RESET       = 32'h0000_0000;
	// ===================================================
	// pipeline events that save or restore context
	typedef enum logic [2:0] {
		CRS_EV_NONE,
		CRS_EV_EXC,     // software exception or accepted maskable interrupt
		CRS_EV_NMI,
		CRS_EV_TCALL,
		CRS_EV_DBG,     // debug trap or illegal opcode
		CRS_EV_INTERRUPT_RETURN_INSTR,
		CRS_EV_DEBUG_RETURN_INSTR,
		CRS_EV_TCRET
	} crs_event_t;
	// system register access request
	typedef struct packed {
		logic        load;   // sysreg_load_instr
		logic        store;  // sysreg_store_instr
		logic [4:0]  num;
		logic [31:0] wdata;
	} crs_sr_req_t;
	// general register write port
	typedef struct packed {
		logic        en;
		logic [4:0]  addr;
		logic [31:0] data;
	} crs_gpr_wr_t;
endpackage : crs_pkg

//--- hw/crs_cpu_register_set.sv
// cpu register set: general registers, program counter and system registers
// Operation
// - all registers thirty-two bits wide
// - thirty-two general registers for data or addresses
// - zero register always reads zero
// - register thirty is short load/store base
// - program counter keeps low 26 bits only
// - carry out of pc bit 25 dropped
// - program counter bit zero always zero
// - system registers reached by number via load/store
// - system register number decode map
// - cause code readable, load cannot alter it
// - debug pair usable only inside debug trap
// - return ignores saved address bit zero
// - exception saves pc and status word
// - nmi saves into nmi pair only
// - saved address is next instruction address
// - reserved upper bits of saves read zero; a load into the table-call or debug pair keeps and reads back all 32 bits
// - interrupt return restores pc and status
// - status word resets to interrupt-disable only
// - status load effective on completion, holds interrupts
module crs_cpu_register_set #(
	parameter int NREGS = 32
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [4:0]           rd_a_addr,    // operand read port a
	input  wire logic [4:0]           rd_b_addr,    // operand read port b
	output logic [31:0]               rd_a_data,
	output logic [31:0]               rd_b_data,
	output logic [31:0]               elem_base,    // base for short load/store
	input  wire crs_pkg::crs_gpr_wr_t gpr_wr,       // result write
	input  wire logic                 pc_load,      // step or branch
	input  wire logic [31:0]          pc_next,      // new pc from pipeline
	input  wire logic [31:0]          pc_ret_addr,  // next-instruction address for saves
	output logic [31:0]               pc,
	input  wire crs_pkg::crs_event_t  event_kind,
	input  wire logic [31:0]          event_cause,  // code latched on exc/nmi/dbg
	input  wire logic [31:0]          tc_target,    // table call jump target
	input  wire crs_pkg::crs_sr_req_t sr_req,
	output logic [31:0]               sr_rdata,
	output logic                      sr_denied,    // access refused, no effect
	output logic [31:0]               program_status_word,
	output logic                      int_hold,     // holds off interrupt acceptance
	output logic                      dbg_active
);
	// ===================================================
	// general register array
	logic [31:0] gpr_ff [NREGS];      // entry 0 never read
	logic [31:0] nxt_gpr [NREGS];

	// write decode; zero target discarded
	always_comb
	begin
		for (int i = 0; i < NREGS; i++)
		begin
			nxt_gpr[i] = gpr_ff[i];
		end
		if (gpr_wr.en && gpr_wr.addr != crs_pkg::ZERO_REG_IDX)
		begin
			nxt_gpr[gpr_wr.addr] = gpr_wr.data;
		end
	end

	// register the array
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NREGS; i++)
			begin
				gpr_ff[i] <= 32'h0000_0000;
			end
		end
		else
		begin
			gpr_ff <= nxt_gpr;
		end
	end

	// reads: no bypass, pipeline forwards its own results
	assign rd_a_data = (rd_a_addr == crs_pkg::ZERO_REG_IDX) ? 32'h0000_0000
		: gpr_ff[rd_a_addr];
	assign rd_b_data = (rd_b_addr == crs_pkg::ZERO_REG_IDX) ? 32'h0000_0000
		: gpr_ff[rd_b_addr];
	assign elem_base = gpr_ff[crs_pkg::ELEM_BASE_IDX];

	// ===================================================
	// program counter and system registers
	logic [25:0] pc_ff, nxt_pc;           // only valid bits stored
	logic [25:0] exc_return_pc_ff, nxt_exc_return_pc;
	logic [7:0]  eist_ff, nxt_eist;
	logic [25:0] nmipc_ff, nxt_nmipc;
	logic [7:0]  nmist_ff, nxt_nmist;
	logic [31:0] tcpc_ff, nxt_tcpc;
	logic [31:0] tcst_ff, nxt_tcst;
	logic [31:0] debug_return_pc_ff, nxt_debug_return_pc;
	logic [31:0] dbst_ff, nxt_dbst;
	logic [31:0] tcbase_ff, nxt_tcbase;
	logic [31:0] cause_ff, nxt_cause;
	logic [7:0]  psw_ff, nxt_psw;
	logic        dbg_ff, nxt_dbg;         // inside debug trap window
	logic        hold_ff, nxt_hold;       // status load completing
	logic        dbg_num;                 // request targets debug pair
	logic        wr_ok;

	// pc masking helper: drop bit 0 and upper bits
	function automatic logic [25:0] crs_pc_fix(input logic [31:0] v);
		crs_pc_fix = {v[25:1], 1'b0};
	endfunction : crs_pc_fix

	assign dbg_num = (sr_req.num == crs_pkg::SR_DBG_RET_PC) || (sr_req.num == crs_pkg::SR_DBG_STAT);
	// debug pair refused outside the trap window
	assign sr_denied = (sr_req.load || sr_req.store) && dbg_num && !dbg_ff;
	assign wr_ok = sr_req.load && !sr_denied;

	// next-state for pc and system registers; events win over loads
	always_comb
	begin
		nxt_pc     = pc_ff;
		nxt_exc_return_pc   = exc_return_pc_ff;
		nxt_eist   = eist_ff;
		nxt_nmipc  = nmipc_ff;
		nxt_nmist  = nmist_ff;
		nxt_tcpc   = tcpc_ff;
		nxt_tcst   = tcst_ff;
		nxt_debug_return_pc   = debug_return_pc_ff;
		nxt_dbst   = dbst_ff;
		nxt_tcbase = tcbase_ff;
		nxt_cause  = cause_ff;
		nxt_psw    = psw_ff;
		nxt_dbg    = dbg_ff;
		nxt_hold   = 1'b0;
		if (pc_load)
		begin
			nxt_pc = crs_pc_fix(pc_next);
		end
		// system register load; cause code and reserved numbers ignored
		if (wr_ok)
		begin
			case (sr_req.num)
				crs_pkg::SR_EXC_RET_PC: nxt_exc_return_pc   = sr_req.wdata[25:0];
				crs_pkg::SR_EXC_STAT:   nxt_eist   = sr_req.wdata[7:0];
				crs_pkg::SR_NMI_RET_PC: nxt_nmipc  = sr_req.wdata[25:0];
				crs_pkg::SR_NMI_STAT:   nxt_nmist  = sr_req.wdata[7:0];
				crs_pkg::SR_PSW:
				begin
					nxt_psw  = sr_req.wdata[7:0];
					nxt_hold = 1'b1;
				end
				crs_pkg::SR_TC_RET_PC:  nxt_tcpc   = sr_req.wdata;
				crs_pkg::SR_TC_STAT:    nxt_tcst   = sr_req.wdata;
				crs_pkg::SR_DBG_RET_PC: nxt_debug_return_pc   = sr_req.wdata;
				crs_pkg::SR_DBG_STAT:   nxt_dbst   = sr_req.wdata;
				crs_pkg::SR_TC_BASE:    nxt_tcbase = sr_req.wdata;
				default:                nxt_psw    = nxt_psw; // undefined numbers: no effect
			endcase
		end
		// context save and restore
		case (event_kind)
			crs_pkg::CRS_EV_EXC:
			begin
				nxt_exc_return_pc  = crs_pc_fix(pc_ret_addr);
				nxt_eist  = psw_ff;
				nxt_cause = event_cause;
			end
			crs_pkg::CRS_EV_NMI:
			begin
				nxt_nmipc = crs_pc_fix(pc_ret_addr);
				nxt_nmist = psw_ff;
				nxt_cause = event_cause;
			end
			crs_pkg::CRS_EV_TCALL:
			begin
				nxt_tcpc = {6'h00, crs_pc_fix(pc_ret_addr)};
				nxt_tcst = {24'h000000, psw_ff};
				nxt_pc   = crs_pc_fix(tc_target);
			end
			crs_pkg::CRS_EV_DBG:
			begin
				nxt_debug_return_pc  = {6'h00, crs_pc_fix(pc_ret_addr)};
				nxt_dbst  = {24'h000000, psw_ff};
				nxt_cause = event_cause;
				nxt_dbg   = 1'b1;
			end
			crs_pkg::CRS_EV_INTERRUPT_RETURN_INSTR:
			begin
				nxt_pc  = crs_pc_fix({6'h00, exc_return_pc_ff});
				nxt_psw = eist_ff;
			end
			crs_pkg::CRS_EV_DEBUG_RETURN_INSTR:
			begin
				nxt_pc  = crs_pc_fix(debug_return_pc_ff);
				nxt_psw = dbst_ff[7:0];
				nxt_dbg = 1'b0;
			end
			crs_pkg::CRS_EV_TCRET:
			begin
				nxt_pc  = crs_pc_fix(tcpc_ff);
				nxt_psw = tcst_ff[7:0];
			end
			default:
			begin
				nxt_dbg = nxt_dbg; // no event
			end
		endcase
	end

	// register pc and system registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pc_ff     <= crs_pkg::PC_RESET[25:0];
			exc_return_pc_ff   <= crs_pkg::SR_RESET[25:0];
			eist_ff   <= crs_pkg::SR_RESET[7:0];
			nmipc_ff  <= crs_pkg::SR_RESET[25:0];
			nmist_ff  <= crs_pkg::SR_RESET[7:0];
			tcpc_ff   <= crs_pkg::SR_RESET;
			tcst_ff   <= crs_pkg::SR_RESET;
			debug_return_pc_ff   <= crs_pkg::SR_RESET;
			dbst_ff   <= crs_pkg::SR_RESET;
			tcbase_ff <= crs_pkg::SR_RESET;
			cause_ff  <= crs_pkg::SR_RESET;
			psw_ff    <= crs_pkg::PSW_RESET[7:0];
			dbg_ff    <= 1'b0;
			hold_ff   <= 1'b0;
		end
		else
		begin
			pc_ff     <= nxt_pc;
			exc_return_pc_ff   <= nxt_exc_return_pc;
			eist_ff   <= nxt_eist;
			nmipc_ff  <= nxt_nmipc;
			nmist_ff  <= nxt_nmist;
			tcpc_ff   <= nxt_tcpc;
			tcst_ff   <= nxt_tcst;
			debug_return_pc_ff   <= nxt_debug_return_pc;
			dbst_ff   <= nxt_dbst;
			tcbase_ff <= nxt_tcbase;
			cause_ff  <= nxt_cause;
			psw_ff    <= nxt_psw;
			dbg_ff    <= nxt_dbg;
			hold_ff   <= nxt_hold;
		end
	end

	// upper bits forced zero on every view
	assign pc         = {6'h00, pc_ff};
	assign program_status_word        = {24'h000000, psw_ff};
	assign dbg_active = dbg_ff;
	// hold acceptance in the load cycle and for one cycle after the value lands
	assign int_hold   = hold_ff || (wr_ok && sr_req.num == crs_pkg::SR_PSW);

	// system register store read mux; reserved numbers read zero
	always_comb
	begin
		sr_rdata = 32'h0000_0000;
		if (sr_req.store && !sr_denied)
		begin
			case (sr_req.num)
				crs_pkg::SR_EXC_RET_PC: sr_rdata = {6'h00, exc_return_pc_ff};
				crs_pkg::SR_EXC_STAT:   sr_rdata = {24'h000000, eist_ff};
				crs_pkg::SR_NMI_RET_PC: sr_rdata = {6'h00, nmipc_ff};
				crs_pkg::SR_NMI_STAT:   sr_rdata = {24'h000000, nmist_ff};
				crs_pkg::SR_CAUSE:      sr_rdata = cause_ff;
				crs_pkg::SR_PSW:        sr_rdata = {24'h000000, psw_ff};
				crs_pkg::SR_TC_RET_PC:  sr_rdata = tcpc_ff;
				crs_pkg::SR_TC_STAT:    sr_rdata = tcst_ff;
				crs_pkg::SR_DBG_RET_PC: sr_rdata = debug_return_pc_ff;
				crs_pkg::SR_DBG_STAT:   sr_rdata = dbst_ff;
				crs_pkg::SR_TC_BASE:    sr_rdata = tcbase_ff;
				default:                sr_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ===================================================
	// assertions
	a_pc_bit_zero: assert property (@(posedge clk) disable iff (rst)
		pc[0] == 1'b0 && pc[31:26] == 6'h00)
		else $error("pc low or upper bits set");
	a_pc_wrap: assert property (@(posedge clk) disable iff (rst)
		pc_load && event_kind == crs_pkg::CRS_EV_NONE |=> pc[25:1] == $past(pc_next[25:1]))
		else $error("pc load wrong");
	a_zero_reads: assert property (@(posedge clk) disable iff (rst)
		rd_a_addr == 5'h00 |-> rd_a_data == 32'h0000_0000)
		else $error("zero reg nonzero");
	a_exc_save_pc: assert property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_EXC |=>
		exc_return_pc_ff == $past({pc_ret_addr[25:1], 1'b0}) && eist_ff == $past(psw_ff))
		else $error("exception save wrong");
	a_nmi_keeps_exc: assert property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_NMI && !sr_req.load |=>
		$stable(exc_return_pc_ff) && nmist_ff == $past(psw_ff))
		else $error("nmi save wrong");
	a_interrupt_return_instr_restore: assert property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_INTERRUPT_RETURN_INSTR |=>
		program_status_word[7:0] == $past(eist_ff) && pc[25:0] == {$past(exc_return_pc_ff[25:1]), 1'b0})
		else $error("interrupt_return_instr restore wrong");
	a_cause_no_load: assert property (@(posedge clk) disable iff (rst)
		sr_req.load && sr_req.num == crs_pkg::SR_CAUSE && event_kind == crs_pkg::CRS_EV_NONE
		|=> $stable(cause_ff))
		else $error("cause altered by load");
	// a refused load must leave the debug pair untouched, not only raise the flag
	a_dbg_refused: assert property (@(posedge clk) disable iff (rst)
		!dbg_ff && sr_req.load && dbg_num && event_kind == crs_pkg::CRS_EV_NONE
		|-> sr_denied ##1 ($stable(debug_return_pc_ff) && $stable(dbst_ff)))
		else $error("debug pair open outside trap");
	a_psw_hold: assert property (@(posedge clk) disable iff (rst)
		wr_ok && sr_req.num == crs_pkg::SR_PSW |-> int_hold ##1 int_hold)
		else $error("interrupt not held on status load");
	a_wr_zero_drop: assert property (@(posedge clk) disable iff (rst)
		gpr_ff[0] == 32'h0000_0000)
		else $error("zero register entry written");
	a_gpr_write: assert property (@(posedge clk) disable iff (rst)
		gpr_wr.en && gpr_wr.addr != crs_pkg::ZERO_REG_IDX |=>
		gpr_ff[$past(gpr_wr.addr)] == $past(gpr_wr.data))
		else $error("general register write lost");
	a_debug_return_instr_close: assert property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_DEBUG_RETURN_INSTR |=> !dbg_active)
		else $error("debug window still open");
	c_exc_then_interrupt_return_instr: cover property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_EXC ##[1:20] event_kind == crs_pkg::CRS_EV_INTERRUPT_RETURN_INSTR);
	c_dbg_access: cover property (@(posedge clk) disable iff (rst)
		dbg_ff && sr_req.store && dbg_num);
	c_psw_load: cover property (@(posedge clk) disable iff (rst)
		wr_ok && sr_req.num == crs_pkg::SR_PSW);
	c_tcall_tcret: cover property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_TCALL ##[1:20] event_kind == crs_pkg::CRS_EV_TCRET);
	c_nmi_save: cover property (@(posedge clk) disable iff (rst)
		event_kind == crs_pkg::CRS_EV_NMI);
endmodule : crs_cpu_register_set

//--- tb/crs_pipe_model.sv
// pipeline stand-in: steps or redirects the program counter
module crs_pipe_model
(
	input  wire logic        step,
	input  wire logic        jump,
	input  wire logic [31:0] jump_addr,
	input  wire logic [31:0] pc,
	output logic             pc_load,
	output logic [31:0]      pc_next
);
	timeunit 1ns;
	timeprecision 1ns;
	// ===================================================
	// next address
	// plain add: the carry past bit 25 is left for the register set to drop
	always_comb
	begin
		pc_load = step | jump;
		pc_next = jump ? jump_addr : pc + 32'h0000_0002;
	end
endmodule : crs_pipe_model

//--- tb/tb_cpu_register_set.sv
// self-checking bench for the cpu register set
module tb_cpu_register_set;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed
	{
		logic [4:0]  num;   // system register number
		logic [31:0] wdata; // value loaded
		logic [31:0] rexp;  // value expected back
		logic        dexp;  // access refused
	} crs_tb_row_t;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic [4:0]           rd_a_addr = 5'h00;
	logic [4:0]           rd_b_addr = 5'h00;
	logic [31:0]          rd_a_data, rd_b_data, elem_base, pc, sr_rdata, program_status_word, pc_next;
	logic [31:0]          pc_ret_addr = 32'h0abc_dee4; // odd upper bits on purpose
	logic [31:0]          event_cause = 32'h0000_0011;
	logic [31:0]          tc_target = 32'h0000_0000;
	logic [31:0]          jump_addr = 32'h0000_0000;
	logic                 pc_load, sr_denied, int_hold, dbg_active;
	logic                 step = 1'b0;
	logic                 jump = 1'b0;
	crs_pkg::crs_gpr_wr_t gpr_wr = '0;
	crs_pkg::crs_event_t  event_kind = crs_pkg::CRS_EV_NONE;
	crs_pkg::crs_sr_req_t sr_req = '0;
	int                   errors = 0;
	int                   samples_checked = 0;
	// ordinary load/store round trips over defined numbers only, refused ones among them
	crs_tb_row_t rows [11] = '{
		'{5'h00, 32'hffff_fffe, 32'h03ff_fffe, 1'b0},
		'{5'h01, 32'hffff_ffff, 32'h0000_00ff, 1'b0},
		'{5'h02, 32'hffff_fffe, 32'h03ff_fffe, 1'b0},
		'{5'h03, 32'h0000_01a5, 32'h0000_00a5, 1'b0},
		'{5'h04, 32'h5555_5555, 32'h0000_0000, 1'b0},
		'{5'h10, 32'h1234_5678, 32'h1234_5678, 1'b0},
		'{5'h11, 32'h0000_00c3, 32'h0000_00c3, 1'b0},
		'{5'h14, 32'hcafe_f00d, 32'hcafe_f00d, 1'b0},
		'{5'h14, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{5'h13, 32'h3333_3333, 32'h0000_0000, 1'b1},
		'{5'h12, 32'h2222_2222, 32'h0000_0000, 1'b1}};
	// ===================================================
	// clock and instances
	always #50 clk = ~clk;
	crs_cpu_register_set #(.NREGS(32)) uut (.clk(clk), .rst(rst), .rd_a_addr(rd_a_addr),
		.rd_b_addr(rd_b_addr), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
		.elem_base(elem_base), .gpr_wr(gpr_wr), .pc_load(pc_load), .pc_next(pc_next),
		.pc_ret_addr(pc_ret_addr), .pc(pc), .event_kind(event_kind),
		.event_cause(event_cause), .tc_target(tc_target), .sr_req(sr_req),
		.sr_rdata(sr_rdata), .sr_denied(sr_denied), .program_status_word(program_status_word), .int_hold(int_hold),
		.dbg_active(dbg_active));
	crs_pipe_model pipe (.step(step), .jump(jump), .jump_addr(jump_addr), .pc(pc),
		.pc_load(pc_load), .pc_next(pc_next));
	// ===================================================
	// shared tasks
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			errors++;
		end
	endtask : check
	// one-cycle load request, taken at the edge that drops it
	task automatic sr_load(input logic [4:0] num, input logic [31:0] wdata);
		@(posedge clk) sr_req <= '{1'b1, 1'b0, num, wdata};
		@(posedge clk) sr_req <= '0;
	endtask : sr_load
	// store request held over a cycle; answer is combinational
	task automatic sr_chk(input logic [4:0] num, input logic [31:0] exp);
		@(posedge clk) sr_req <= '{1'b0, 1'b1, num, 32'h0000_0000};
		@(negedge clk);
		check("sr_rdata", exp, sr_rdata);
	endtask : sr_chk
	task automatic ev(input crs_pkg::crs_event_t kind);
		@(posedge clk) event_kind <= kind;
		@(posedge clk) event_kind <= crs_pkg::CRS_EV_NONE;
	endtask : ev
	task automatic gpr_write(input logic [4:0] addr, input logic [31:0] data);
		@(posedge clk) gpr_wr <= '{1'b1, addr, data};
		@(posedge clk) gpr_wr <= '0;
	endtask : gpr_write
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	// ===================================================
	// watchdog: a hung sequence counts as a mismatch
	initial
	begin
		repeat (2000) @(posedge clk);
		errors++;
		print_verdict();
	end
	// ===================================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("pc", crs_pkg::PC_RESET, pc);
		check("psw", 32'h0000_0020, program_status_word);
		check("dbg_active", 32'h0, {31'h0, dbg_active});
		foreach (rows[i])
		begin
			sr_load(rows[i].num, rows[i].wdata);
			sr_chk(rows[i].num, rows[i].rexp);
			check("sr_denied", {31'h0, rows[i].dexp}, {31'h0, sr_denied});
		end
		// zero register, element base, two reads at once
		gpr_write(5'h00, 32'hdead_beef);
		gpr_write(5'h1e, 32'h1111_2222);
		gpr_write(5'h1f, 32'ha5a5_5a5a);
		@(posedge clk) rd_b_addr <= 5'h1f;
		@(negedge clk);
		check("rd_a_data", 32'h0000_0000, rd_a_data);
		check("rd_b_data", 32'ha5a5_5a5a, rd_b_data);
		check("elem_base", 32'h1111_2222, elem_base);
		// swap the ports so each one sees both a live entry and the zero entry
		@(posedge clk) rd_a_addr <= 5'h1e;
		rd_b_addr <= 5'h00;
		@(negedge clk);
		check("rd_a_data", 32'h1111_2222, rd_a_data);
		check("rd_b_data", 32'h0000_0000, rd_b_data);
		// program counter width, odd bit and wrap
		@(posedge clk) jump <= 1'b1;
		jump_addr <= 32'hffff_ffff;
		@(posedge clk) jump <= 1'b0;
		step <= 1'b1;
		@(negedge clk);
		check("pc", 32'h03ff_fffe, pc);
		@(posedge clk) step <= 1'b0;
		@(negedge clk);
		check("pc", 32'h0000_0000, pc);
		// status word load holds interrupts off until one cycle after it lands
		@(posedge clk) sr_req <= '{1'b1, 1'b0, crs_pkg::SR_PSW, 32'h0000_0080};
		@(negedge clk);
		check("int_hold", 32'h1, {31'h0, int_hold});
		check("psw", 32'h0000_0020, program_status_word);
		@(posedge clk) sr_req <= '0;
		@(negedge clk);
		check("psw", 32'h0000_0080, program_status_word);
		check("int_hold", 32'h1, {31'h0, int_hold});
		@(negedge clk);
		check("int_hold", 32'h0, {31'h0, int_hold});
		// exception save, nmi save into its own pair, then return
		ev(crs_pkg::CRS_EV_EXC);
		sr_chk(5'h00, 32'h02bc_dee4);
		sr_chk(5'h01, 32'h0000_0080);
		sr_chk(5'h04, 32'h0000_0011);
		// odd return address on purpose: the restore must drop bit zero
		sr_load(5'h00, 32'h0000_1235);
		sr_load(5'h01, 32'h0000_0041);
		ev(crs_pkg::CRS_EV_NMI);
		sr_chk(5'h02, 32'h02bc_dee4);
		sr_chk(5'h00, 32'h0000_1235);
		ev(crs_pkg::CRS_EV_INTERRUPT_RETURN_INSTR);
		@(negedge clk);
		check("pc", 32'h0000_1234, pc);
		check("psw", 32'h0000_0041, program_status_word);
		// debug pair reachable only inside the trap
		ev(crs_pkg::CRS_EV_DBG);
		sr_chk(5'h13, 32'h0000_0041);
		sr_load(5'h12, 32'h0000_4444);
		sr_chk(5'h12, 32'h0000_4444);
		check("dbg_active", 32'h1, {31'h0, dbg_active});
		ev(crs_pkg::CRS_EV_DEBUG_RETURN_INSTR);
		sr_chk(5'h13, 32'h0000_0000);
		check("sr_denied", 32'h1, {31'h0, sr_denied});
		check("pc", 32'h0000_4444, pc);
		check("dbg_active", 32'h0, {31'h0, dbg_active});
		// table call saves its pair and jumps, table return restores both
		@(posedge clk) tc_target <= 32'h0000_3001;
		ev(crs_pkg::CRS_EV_TCALL);
		sr_chk(5'h10, 32'h02bc_dee4);
		check("pc", 32'h0000_3000, pc);
		sr_chk(5'h11, 32'h0000_0041);
		sr_load(5'h11, 32'h0000_0007);
		ev(crs_pkg::CRS_EV_TCRET);
		@(negedge clk);
		check("pc", 32'h02bc_dee4, pc);
		check("psw", 32'h0000_0007, program_status_word);
		// second reset in mid-run, taken inside a debug trap
		ev(crs_pkg::CRS_EV_DBG);
		@(posedge clk) rst <= 1'b1;
		@(negedge clk);
		check("pc", crs_pkg::PC_RESET, pc);
		check("psw", 32'h0000_0020, program_status_word);
		check("dbg_active", 32'h0, {31'h0, dbg_active});
		@(posedge clk) rst <= 1'b0;
		sr_chk(5'h00, 32'h0000_0000);
		check("int_hold", 32'h0, {31'h0, int_hold});
		print_verdict();
	end
endmodule : tb_cpu_register_set
